// ==== src/slr_pkg.sv ====
// package: register map, field layout and reset values of the link and state registers
package slr_pkg;
  localparam int SLR_AW = 16;
  localparam int SLR_DW = 16;
  localparam logic [15:0] SLR_OFS_RW_OFFSET = 16'h0108;
  localparam logic [15:0] SLR_OFS_LINK_STATUS = 16'h0110;
  localparam logic [15:0] SLR_OFS_STATE_REQ = 16'h0120;
  localparam logic [15:0] SLR_OFS_STATE_STAT = 16'h0130;
  // state codes
  localparam logic [3:0] SLR_ST_INIT = 4'h1;
  localparam logic [3:0] SLR_ST_PREOP = 4'h2;
  localparam logic [3:0] SLR_ST_BOOT = 4'h3;
  localparam logic [3:0] SLR_ST_SAFEOP = 4'h4;
  localparam logic [3:0] SLR_ST_OP = 4'h8;
  // field positions
  localparam int SLR_STATE_LSB = 0;
  localparam int SLR_STATE_W = 4;
  localparam int SLR_ACK_BIT = 4;
  localparam int SLR_IDREQ_BIT = 5;
  localparam int SLR_ERR_BIT = 4;
  localparam int SLR_IDVAL_BIT = 5;
  localparam int SLR_LS_OPER_BIT = 0;
  localparam int SLR_LS_WDOG_BIT = 1;
  localparam int SLR_LS_ELD_BIT = 2;
  localparam int SLR_LS_LINK_LSB = 4;
  localparam int SLR_LS_LOOP_LSB = 8;
  localparam int SLR_NPORTS = 4;
  // writable masks
  localparam logic [15:0] SLR_REQ_MASK = 16'h003f;
  localparam logic [15:0] SLR_STAT_MASK = 16'h003f;
  localparam logic [15:0] SLR_RESET_STATE = 16'h0001;
  localparam logic [15:0] SLR_RESET_ZERO = 16'h0000;
  localparam logic [1:0] SLR_LOOP_HOLD_INIT = 2'h0;
endpackage

// ==== src/slr_loop_port.sv ====
// one port's loop state holder: applies new loop setting only between frames
`timescale 1ns/100ps
`default_nettype none
module slr_loop_port
  import slr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // requested loop state and frame activity
  input wire logic loop_closed_req,
  input wire logic frame_busy,
  // applied loop state
  output logic loop_closed
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loop_closed <= 1'b1;
    end else if (!frame_busy) begin
      loop_closed <= loop_closed_req; // RL2
    end
  end
endmodule
`default_nettype wire

// ==== src/slr_regs.sv ====
// register bank: r/w offset, link-layer status, state request and state status
`timescale 1ns/100ps
`default_nettype none
// How it works
// RL1: combined read-write commands write to command address plus stored 16-bit offset.
// RL2: loop configuration changes wait until the port's current frame ends.
// RL3: configurer keeps receive fifo size 7 unless clocks within 25ppm; this block has no receive fifo setting.
// RL4: status bit 0 set only when config loaded and host interface operational.
// RL5: status bit 1 shows host watchdog, 0 expired, 1 reloaded.
// RL6: status bit 2 enhanced link; setting latched at first config load only.
// RL7: status bits 4 to 7 show physical link on ports 0 to 3.
// RL8: bit 8+2n loop closed, bit 9+2n stable communication, per port.
// RL9: network read of link-layer status clears its network event flag.
// RL10: master requests transitions with 4-bit state codes 1,2,3,4,8.
// RL11: acknowledge bit set in request acknowledges pending error indication.
// RL12: request carries identification bit; status identification bit one higher; the code uses bit 5 for both.
// RL13: without emulation a network write locks request until host access.
// RL14: host access to either request byte unlocks the whole register.
// RL15: with emulation request always writable and copied into status.
// RL16: without ack-by-write host read clears event flag, host writes ignored.
// RL17: with ack-by-write host write clears event flag, value not stored.
// RL18: status low 4 bits report actual state with request codes.
// RL19: status error bit 4 set on failed or local change, else clear.
// RL20: status bit 5 shows identification value loaded and valid.
// RL21: host writes status only without emulation; else status mirrors request.
// RL22: network read of state status clears its network event flag.
// RL23: emulation setting selects host-written or request-following status.
// RL24: a configuration bit selects ack-by-write or ack-by-read.
// RL25: network write while request is locked is discarded.
// RL26: reserved bits read zero and ignore writes.
module slr_regs
  import slr_pkg::*;
#(
  parameter int NPORTS = SLR_NPORTS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // network side register access
  input wire logic net_wr,
  input wire logic net_rd,
  input wire logic [slr_pkg::SLR_AW-1:0] net_addr,
  input wire logic [1:0] net_be,
  input wire logic [slr_pkg::SLR_DW-1:0] net_wdata,
  output logic [slr_pkg::SLR_DW-1:0] net_rdata,
  // combined read-write command address generation
  input wire logic [slr_pkg::SLR_AW-1:0] cmd_addr,
  output logic [slr_pkg::SLR_AW-1:0] cmd_rd_addr,
  output logic [slr_pkg::SLR_AW-1:0] cmd_wr_addr,
  // local host side register access
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [slr_pkg::SLR_AW-1:0] host_addr,
  input wire logic [1:0] host_be,
  input wire logic [slr_pkg::SLR_DW-1:0] host_wdata,
  output logic [slr_pkg::SLR_DW-1:0] host_rdata,
  // configuration
  input wire logic emulation,
  input wire logic ack_by_write,
  input wire logic config_load_done,
  input wire logic config_eld_setting,
  input wire logic host_operational,
  input wire logic host_wdog_ok,
  input wire logic id_loaded,
  // port state
  input wire logic [NPORTS-1:0] port_link,
  input wire logic [NPORTS-1:0] port_loop_req,
  input wire logic [NPORTS-1:0] port_frame_busy,
  input wire logic [NPORTS-1:0] port_comm_ok,
  // event flag clear strobes and status
  output logic clr_link_status_event,
  output logic clr_state_status_event,
  output logic clr_app_layer_event,
  output logic state_req_locked,
  output logic pd_access_enable
);
  import slr_pkg::*;

  // ==========================================================
  // address decode
  // bit 0 picks the byte lane, so both bytes of a register share one decode
  function automatic logic hit(input logic [SLR_AW-1:0] a, input logic [SLR_AW-1:0] base);
    hit = (a[SLR_AW-1:1] == base[SLR_AW-1:1]);
  endfunction

  // disabled lanes and reserved bits keep their old value
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge = (old & ~m) | (nw & m);
  endfunction

  // one strobe per register and side, qualified by the access type except host_acc_req, which takes any host access
  logic net_wr_off;
  logic net_wr_req;
  logic net_rd_ls;
  logic net_rd_ss;
  logic host_acc_req;
  logic host_wr_ss;
  assign net_wr_off = net_wr && hit(net_addr, SLR_OFS_RW_OFFSET);
  assign net_wr_req = net_wr && hit(net_addr, SLR_OFS_STATE_REQ) && (|net_be);
  assign net_rd_ls = net_rd && hit(net_addr, SLR_OFS_LINK_STATUS);
  assign net_rd_ss = net_rd && hit(net_addr, SLR_OFS_STATE_STAT);
  // either byte lane of the request counts as an access to the whole mailbox
  assign host_acc_req = hit(host_addr, SLR_OFS_STATE_REQ) && (|host_be); // RL14
  assign host_wr_ss = host_wr && hit(host_addr, SLR_OFS_STATE_STAT);

  // ==========================================================
  // r/w command offset
  logic [15:0] rw_command_offset;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rw_command_offset <= SLR_RESET_ZERO;
    end else if (net_wr_off) begin
      rw_command_offset <= merge(rw_command_offset, net_wdata, net_be, 16'hffff);
    end
  end
  // only the write half of a combined command is moved; the read half uses the
  // address as given
  assign cmd_rd_addr = cmd_addr; // RL1
  // the sum wraps at the width of the address space
  assign cmd_wr_addr = cmd_addr + rw_command_offset; // RL1

  // ==========================================================
  // link-layer status
  logic [NPORTS-1:0] loop_closed;
  // a frame in flight keeps the old loop state so it is never cut in half
  genvar gi;
  generate
    for (gi = 0; gi < NPORTS; gi++) begin : g_port
      slr_loop_port u_loop (
        .clk(clk),
        .resetn(resetn),
        .loop_closed_req(port_loop_req[gi]),
        .frame_busy(port_frame_busy[gi]),
        .loop_closed(loop_closed[gi])
      );
    end
  endgenerate

  // enhanced link setting is taken at the first load only; later reloads leave it alone
  logic eld_taken;
  logic eld_active;
  logic eld_first_load;
  assign eld_first_load = config_load_done && !eld_taken;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eld_taken <= 1'b0;
    end else if (eld_first_load) begin
      eld_taken <= 1'b1; // RL6
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eld_active <= 1'b0;
    end else if (eld_first_load) begin
      eld_active <= config_eld_setting; // RL6
    end
  end

  // the word is rebuilt every cycle from live levels, so a read never shows stale state
  logic ls_oper;
  logic ls_wdog;
  logic ls_eld;
  logic [NPORTS-1:0] ls_link;
  logic [NPORTS-1:0] ls_loop;
  logic [NPORTS-1:0] ls_comm;
  // process data access needs both a good configuration load and a working host
  assign ls_oper = config_load_done && host_operational; // RL4
  assign ls_wdog = host_wdog_ok; // RL5
  assign ls_eld = eld_active; // RL6
  assign ls_link = port_link; // RL7
  assign ls_loop = loop_closed; // RL8
  assign ls_comm = port_comm_ok; // RL8

  logic [15:0] link_layer_status;
  always_comb begin
    // reserved bit and unused port slots stay zero
    link_layer_status = SLR_RESET_ZERO; // RL26
    link_layer_status[SLR_LS_OPER_BIT] = ls_oper; // RL4
    link_layer_status[SLR_LS_WDOG_BIT] = ls_wdog; // RL5
    link_layer_status[SLR_LS_ELD_BIT] = ls_eld; // RL6
    for (int p = 0; p < NPORTS; p++) begin
      link_layer_status[SLR_LS_LINK_LSB + p] = ls_link[p]; // RL7
      link_layer_status[SLR_LS_LOOP_LSB + 2 * p] = ls_loop[p]; // RL8
      link_layer_status[SLR_LS_LOOP_LSB + 2 * p + 1] = ls_comm[p]; // RL8
    end
  end
  // process data memory stays fenced off until the host side is up
  assign pd_access_enable = link_layer_status[SLR_LS_OPER_BIT]; // RL4

  // ==========================================================
  // state request mailbox
  logic [15:0] state_request;
  logic locked;
  logic req_accept;
  logic host_release;
  // a write that meets a locked mailbox is dropped without a trace; the master
  // must read the status to learn whether its request was taken
  assign req_accept = net_wr_req && (emulation || !locked); // RL13 RL15 RL25
  // which host access acknowledges depends on the configured acknowledge mode
  assign host_release = host_acc_req && (ack_by_write ? host_wr : host_rd); // RL16 RL17

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_request <= SLR_RESET_ZERO;
    end else if (req_accept) begin
      // state code, acknowledge and identification bits are latched for the host
      state_request <= merge(state_request, net_wdata, net_be, SLR_REQ_MASK); // RL10 RL11 RL12 RL26
    end
  end

  // a new write in the release cycle still meets the lock and is dropped, so the mailbox comes out unlocked
  logic lock_set;
  logic lock_clear;
  assign lock_set = req_accept && !emulation; // RL13
  assign lock_clear = emulation || host_release; // RL14 RL15

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      locked <= 1'b0; // RL13
    end else if (lock_set) begin
      locked <= 1'b1; // RL13
    end else if (lock_clear) begin
      locked <= 1'b0; // RL14 RL15
    end
  end
  assign state_req_locked = locked;

  // ==========================================================
  // state status
  logic [15:0] state_status;
  logic [15:0] req_merged;
  logic [15:0] emul_status;
  logic ss_from_req;
  logic ss_from_host;
  // under emulation the status takes the value being written, so request and status
  // change in the same cycle instead of one cycle apart
  assign req_merged = merge(state_request, net_wdata, net_be, SLR_REQ_MASK);
  assign emul_status = req_merged & SLR_STAT_MASK; // RL15
  assign ss_from_req = emulation && req_accept; // RL23
  assign ss_from_host = !emulation && host_wr_ss; // RL21

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_status <= SLR_RESET_STATE;
    end else if (ss_from_req) begin
      state_status <= emul_status; // RL15 RL21 RL23
    end else if (ss_from_host) begin
      // host reports actual state, error and identification validity
      state_status <= merge(state_status, host_wdata, host_be, SLR_STAT_MASK); // RL18 RL19 RL20 RL21
    end
  end

  // without emulation, identification only reads valid while a loaded value backs it
  logic [15:0] state_status_rd;
  always_comb begin
    state_status_rd = state_status & SLR_STAT_MASK; // RL26
    if (!emulation) begin
      state_status_rd[SLR_IDVAL_BIT] = state_status[SLR_IDVAL_BIT] && id_loaded; // RL20
    end
  end

  // ==========================================================
  // event flag clears
  // the flags live outside this block; each read or release sends a one-cycle pulse
  // to their owner, who lets a new event win over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clr_link_status_event <= 1'b0;
    end else begin
      clr_link_status_event <= net_rd_ls; // RL9
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clr_state_status_event <= 1'b0;
    end else begin
      clr_state_status_event <= net_rd_ss; // RL22
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clr_app_layer_event <= 1'b0;
    end else begin
      clr_app_layer_event <= host_release; // RL16 RL17 RL24
    end
  end

  // ==========================================================
  // read data
  // unmapped addresses fall through to zero
  function automatic logic [15:0] rd_mux(input logic [SLR_AW-1:0] a, input logic [15:0] off,
                                         input logic [15:0] ls, input logic [15:0] rq,
                                         input logic [15:0] ss);
    if (hit(a, SLR_OFS_RW_OFFSET)) begin
      rd_mux = off;
    end else if (hit(a, SLR_OFS_LINK_STATUS)) begin
      rd_mux = ls;
    end else if (hit(a, SLR_OFS_STATE_REQ)) begin
      rd_mux = rq;
    end else if (hit(a, SLR_OFS_STATE_STAT)) begin
      rd_mux = ss;
    end else begin
      rd_mux = SLR_RESET_ZERO;
    end
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      net_rdata <= SLR_RESET_ZERO;
    end else if (net_rd) begin
      // network read data is held until the next network read
      net_rdata <= rd_mux(net_addr, rw_command_offset, link_layer_status, state_request,
                          state_status_rd);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      host_rdata <= SLR_RESET_ZERO;
    end else if (host_rd) begin
      // host read data is held until the next host read
      host_rdata <= rd_mux(host_addr, rw_command_offset, link_layer_status, state_request,
                           state_status_rd);
    end
  end
endmodule
`default_nettype wire

// ==== testbench/slr_regs_sva.sv ====
// checker: port-level assertions for the link and state register bank
`timescale 1ns/100ps
`default_nettype none
// ====================
// checker
module slr_regs_sva
  import slr_pkg::*;
(
  input wire logic clk, resetn, net_wr, net_rd, host_wr, host_rd,
  input wire logic [15:0] net_addr, net_wdata, cmd_addr, cmd_rd_addr, cmd_wr_addr, host_addr,
  input wire logic [1:0] net_be,
  input wire logic emulation, ack_by_write, config_load_done, host_operational,
  input wire logic clr_link_status_event, clr_state_status_event, clr_app_layer_event,
  input wire logic state_req_locked, pd_access_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_net_lock;
    net_wr && net_addr[15:1] == 15'h0090 && !emulation;
  endsequence
  sequence s_host_release;
    state_req_locked && !emulation && host_addr[15:1] == 15'h0090 &&
      (ack_by_write ? host_wr : host_rd);
  endsequence
  chk_rd_addr: assert property (cmd_rd_addr == cmd_addr)
    else $error("read address differs");
  chk_wr_offset: assert property (
    net_wr && net_addr[15:1] == 15'h0084 && net_be == 2'h3 |=>
      cmd_wr_addr == cmd_addr + $past(net_wdata)) else $error("write address wrong");
  chk_link_clear: assert property (
    net_rd && net_addr[15:1] == 15'h0088 |=> clr_link_status_event)
    else $error("link event not cleared");
  chk_stat_clear: assert property (
    net_rd && net_addr[15:1] == 15'h0098 |=> clr_state_status_event)
    else $error("status event not cleared");
  chk_lock_set: assert property (s_net_lock |=> state_req_locked)
    else $error("request not locked");
  chk_lock_release: assert property (
    s_host_release ##0 !net_wr |=> !state_req_locked && clr_app_layer_event)
    else $error("request not released");
  chk_emul_unlock: assert property (emulation [*2] |-> !state_req_locked)
    else $error("locked under emulation");
  chk_pd_on: assert property (
    (config_load_done && host_operational) [*2] |-> pd_access_enable)
    else $error("process data access off");
endmodule
`default_nettype wire

// ==== testbench/slr_net_master.sv ====
// network master model: one-cycle accesses on the network side
`timescale 1ns/100ps
`default_nettype none
// ====================
// master
module slr_net_master
(
  input wire logic clk,
  output logic net_wr = 1'b0,
  output logic net_rd = 1'b0,
  output logic [1:0] net_be = 2'h0,
  output logic [15:0] net_addr = 16'h0000,
  output logic [15:0] net_wdata = 16'h0000
);
  // qualifiers are cleared and address and data scrambled once released
  task automatic access(input logic wr, input logic [15:0] a, d);
    @(negedge clk);
    {net_wr, net_rd, net_addr, net_wdata, net_be} = {wr, !wr, a, d, 2'h3};
    @(negedge clk);
    {net_wr, net_rd, net_addr, net_wdata, net_be} = {2'b00, ~a, ~d, 2'h0};
  endtask
endmodule
`default_nettype wire

// ==== testbench/test_slr_regs.sv ====
// testbench: link and state register bank with a network master model
`timescale 1ns/100ps
`default_nettype none
// ====================
// bench
module test_slr_regs;
  import slr_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, pend = 1'b0, from_host = 1'b0;
  logic net_wr, net_rd, host_wr, host_rd, emulation, ack_by_write, config_load_done;
  logic config_eld_setting, host_operational, host_wdog_ok, id_loaded;
  logic [1:0] net_be, host_be;
  logic [15:0] net_addr, net_wdata, net_rdata, cmd_addr, cmd_rd_addr, cmd_wr_addr;
  logic [15:0] host_addr, host_wdata, host_rdata, exp, v;
  logic [3:0] port_link, port_loop_req, port_frame_busy, port_comm_ok, lp;
  logic clr_link_status_event, clr_state_status_event, clr_app_layer_event;
  logic state_req_locked, pd_access_enable;
  logic [15:0] exp_q[$];
  logic [3:0] codes[5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
  integer seed = 32'h5cc0482e;
  int err_total = 0;
  int checked = 0;
  always #5 clk = ~clk;
  slr_regs i_dut (.*);
  slr_net_master u_net (.*);
  task automatic check(input string name, input logic [15:0] seen, want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic host_acc(input logic wr, input logic [15:0] a, d);
    @(negedge clk);
    {host_wr, host_rd, host_addr, host_wdata} = {wr, !wr, a, d};
    @(negedge clk);
    {host_wr, host_rd, host_addr, host_wdata} = {2'b00, ~a, ~d};
  endtask
  // note the expected read data, then issue the read
  task automatic rd(input logic host, input logic [15:0] a, want);
    exp_q.push_back(want);
    if (host) host_acc(1'b0, a, 16'h0000);
    else u_net.access(1'b0, a, 16'h0000);
  endtask
  always @(posedge clk) begin
    pend <= host_rd | net_rd;
    from_host <= host_rd;
  end
  always @(negedge clk) begin
    if (pend === 1'b1 && exp_q.size() > 0)
      check("read data", from_host ? host_rdata : net_rdata, exp_q.pop_front());
  end
  initial begin
    #200000;
    err_total++;
    print_verdict;
  end
  initial begin
    {host_wr, host_rd, host_addr, host_wdata, host_be, cmd_addr} = {2'b00, 32'h0, 2'h3, 16'h0};
    {emulation, ack_by_write, config_load_done, host_operational, host_wdog_ok} = 5'h00;
    {config_eld_setting, id_loaded} = 2'b10;
    {port_link, port_loop_req, port_frame_busy, port_comm_ok} = 16'h0000;
    repeat (12) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    rd(1'b1, SLR_OFS_STATE_REQ, 16'h0000);
    rd(1'b1, SLR_OFS_STATE_STAT, SLR_RESET_STATE);
    rd(1'b0, 16'h0200, 16'h0000);
    v = 16'($random(seed));
    u_net.access(1'b1, SLR_OFS_RW_OFFSET, v);
    rd(1'b0, SLR_OFS_RW_OFFSET, v);
    repeat (3) begin
      @(negedge clk) cmd_addr = 16'($random(seed));
      #1 check("write address", cmd_wr_addr, cmd_addr + v);
    end
    config_load_done = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {port_link, port_comm_ok, port_loop_req} = 12'($random(seed));
      port_frame_busy = {4{i[0]}};
      if (!i[0]) lp = port_loop_req;
      {host_wdog_ok, host_operational} = {i[1], i != 3};
      repeat (3) @(negedge clk);
      exp = {8'h00, port_link, 1'b0, 1'b1, host_wdog_ok, host_operational};
      for (int n = 0; n < 4; n++) {exp[9 + 2 * n], exp[8 + 2 * n]} = {port_comm_ok[n], lp[n]};
      rd(1'b0, SLR_OFS_LINK_STATUS, exp);
      check("link event clear", clr_link_status_event, 1'b1);
      config_eld_setting = 1'b0;
    end
    for (int i = 0; i < 5; i++) begin
      v = {10'h0, i[0], 1'b1, codes[i]};
      u_net.access(1'b1, SLR_OFS_STATE_REQ, v);
      check("locked", state_req_locked, 1'b1);
      u_net.access(1'b1, SLR_OFS_STATE_REQ, 16'h0008);
      host_acc(1'b1, SLR_OFS_STATE_REQ, 16'h0000);
      check("write keeps lock", state_req_locked, 1'b1);
      rd(1'b1, 16'h0121, v);
      check("app event clear", clr_app_layer_event, 1'b1);
      check("unlocked", state_req_locked, 1'b0);
      id_loaded = i[1];
      host_acc(1'b1, SLR_OFS_STATE_STAT, 16'hffc0 | v);
      rd(1'b0, SLR_OFS_STATE_STAT, (v & 16'h001f) | {10'h0, i[0] & i[1], 5'h0});
      check("status event clear", clr_state_status_event, 1'b1);
    end
    ack_by_write = 1'b1;
    u_net.access(1'b1, SLR_OFS_STATE_REQ, 16'h0004);
    rd(1'b1, SLR_OFS_STATE_REQ, 16'h0004);
    check("read keeps lock", state_req_locked, 1'b1);
    host_acc(1'b1, SLR_OFS_STATE_REQ, 16'h0000);
    check("write releases", state_req_locked, 1'b0);
    rd(1'b0, SLR_OFS_STATE_REQ, 16'h0004);
    emulation = 1'b1;
    for (int i = 3; i < 5; i++) begin
      u_net.access(1'b1, SLR_OFS_STATE_REQ, {12'hff0, codes[i]});
      check("emulated unlock", state_req_locked, 1'b0);
      host_acc(1'b1, SLR_OFS_STATE_STAT, 16'h0002);
      rd(1'b1, SLR_OFS_STATE_STAT, {12'h000, codes[i]});
    end
    repeat (2) @(negedge clk);
    check("reads left", 16'(exp_q.size()), 16'h0000);
    print_verdict;
  end
endmodule
bind slr_regs slr_regs_sva i_sva (.*);
`default_nettype wire
